// File: src/sat_dev.sv
// Converter end: chip-select filter, address capture, result shift-out, conversion timing
`timescale 1ns/1ps
module sat_dev (
	// Clock, reset, enable
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	// Link
	sat_link_if.dev                    lnk,
	// Analog front end stand-in
	output logic [sat_pkg::ADDR_W-1:0] chan,
	output logic                       sampling,
	input  wire logic [sat_pkg::RES_W-1:0] ana_data,
	// Status
	output logic [sat_pkg::RES_W-1:0]  result,
	output logic                       conv_busy,
	output logic                       aborted
);
	import sat_pkg::*;
	logic [2:0]          cs_sy_r;
	logic [2:0]          clk_sy_r;
	logic [1:0]          adr_sy_r;
	logic                cs_f_r;
	logic [5:0]          filt_r;
	logic                rise;
	logic                fall;
	logic                en;
	logic                cs_fall;
	logic                cs_rise;
	logic [4:0]          fcnt_r;
	logic [ADDR_W-1:0]   ash_r;
	logic [RES_W-1:0]    osh_r;
	logic [RES_W-1:0]    hold_r;
	logic [9:0]          tmr_r;
	logic                conv_r;
	logic                eoc_r;
	logic                oe_r;
	logic                conv_end;
	logic                abort;
	logic                tenth;
	// Filter window complete; one test shared by the level and both strobes
	function automatic logic win_full(input logic [5:0] n);
		return n == 6'(CS_FILT_CYC - 1);
	endfunction
	// ==========================================================
	// Synchronisers: stage 0 is read only by stage 1
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			cs_sy_r  <= 3'h7;
			clk_sy_r <= 3'h0;
			adr_sy_r <= 2'h0;
		end
		else if (ce)
		begin
			cs_sy_r  <= {cs_sy_r[1:0], lnk.cs_n};
			clk_sy_r <= {clk_sy_r[1:0], lnk.io_clk};
			adr_sy_r <= {adr_sy_r[0], lnk.addr};
		end
	assign rise = clk_sy_r[1] && !clk_sy_r[2];
	assign fall = !clk_sy_r[1] && clk_sy_r[2];
	// ==========================================================
	// Chip-select filter: new level must hold for the whole window
	// Trades a fixed latency on every edge for immunity to glitches
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			cs_f_r <= 1'b1;
			filt_r <= '0;
		end
		else if (ce)
		begin
			if (cs_sy_r[1] == cs_f_r)
				filt_r <= '0;
			else if (win_full(filt_r))
			begin
				cs_f_r <= cs_sy_r[1];
				filt_r <= '0;
			end
			else
				filt_r <= filt_r + 1'b1;
		end
	assign cs_fall = ce && !cs_sy_r[1] && cs_f_r && win_full(filt_r);
	assign cs_rise = ce && cs_sy_r[1] && !cs_f_r && win_full(filt_r);
	// Controls are live only while filtered select is low
	assign en = ce && !cs_f_r;
	assign tenth    = en && fall && (fcnt_r == 5'(CONV_EDGE - 1));
	assign conv_end = ce && conv_r && (tmr_r == 10'(CONV_CYC - 1));
	assign abort    = cs_fall && conv_r && (tmr_r < 10'(ABORT_CYC));
	// ==========================================================
	// Falling-edge counter; reset by frame start, frame end or conversion end
	// Without select, sync is only regained at conversion end
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			fcnt_r <= '0;
		else if (ce)
		begin
			if (cs_fall || cs_rise || conv_end)
				fcnt_r <= '0;
			else if (en && fall && fcnt_r != 5'(FRAME_MAX))
				fcnt_r <= fcnt_r + 1'b1;
		end
	// Address capture on rising edges, first four bits only
	// Later rising edges leave the captured channel untouched
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			ash_r <= '0;
		else if (en && rise && fcnt_r < 5'(ADDR_W))
			ash_r <= {ash_r[ADDR_W-2:0], adr_sy_r[1]};
	// ==========================================================
	// Result shifter: MSB presented first, advanced on falling edges
	// Bits past the tenth shift in as zeros
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			osh_r <= RES_RST;
		else if (ce)
		begin
			if (conv_end)
				osh_r <= hold_r;
			else if (cs_fall)
				osh_r <= result;
			else if (en && fall)
				osh_r <= {osh_r[RES_W-2:0], 1'b0};
		end
	// Data line enable follows the filtered select
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			oe_r <= 1'b0;
		else if (ce)
			oe_r <= !cs_f_r;
	// ==========================================================
	// Channel select and acquisition window, edges four to ten
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			chan     <= '0;
			sampling <= 1'b0;
		end
		else if (ce)
		begin
			if (en && fall && fcnt_r == 5'(ACQ_START - 1) && !conv_r)
			begin
				chan     <= ash_r;
				sampling <= 1'b1;
			end
			else if (tenth || cs_rise)
				sampling <= 1'b0;
		end
	// ==========================================================
	// Conversion timer and end-of-conversion flag
	// Abort outranks start and end, so a cut conversion leaves result alone
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			conv_r  <= 1'b0;
			tmr_r   <= '0;
			eoc_r   <= EOC_RST;
			hold_r  <= RES_RST;
			result  <= RES_RST;
			aborted <= 1'b0;
		end
		else if (ce)
		begin
			if (abort)
			begin
				conv_r  <= 1'b0;
				eoc_r   <= 1'b1;
				aborted <= 1'b1;
			end
			else if (tenth && !conv_r)
			begin
				conv_r  <= 1'b1;
				tmr_r   <= '0;
				eoc_r   <= 1'b0;
				hold_r  <= ana_data;
				aborted <= 1'b0;
			end
			else if (conv_end)
			begin
				conv_r <= 1'b0;
				eoc_r  <= 1'b1;
				result <= hold_r;
			end
			else if (conv_r)
				tmr_r <= tmr_r + 1'b1;
		end
	// ==========================================================
	// Port drive
	assign lnk.dout    = osh_r[RES_W-1];
	assign lnk.dout_oe = oe_r;
	assign lnk.eoc     = eoc_r;
	assign conv_busy   = conv_r;
endmodule

// File: src/sat_fifo.sv
// Small result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sat_fifo #(
	parameter int W = 10,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic         ce,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;
	// ==========================================================
	// Flags from the count, so full and empty are exact
	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	// Storage needs no reset
	always_ff @(posedge clk_sys)
		if (push)
			mem[wp_r] <= in_data;
	// Pointers and count
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule

// File: src/sat_host.sv
// Host end: serial master that frames transfers and queues results
`timescale 1ns/1ps
module sat_host (
	// Clock, reset, enable
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire logic                   ce,
	// Link
	sat_link_if.hst                     lnk,
	// Transfer request
	input  wire logic                   req_valid,
	output logic                        req_ready,
	input  wire logic [sat_pkg::ADDR_W-1:0] req_chan,
	input  wire logic [4:0]             req_len,
	input  wire logic                   req_use_cs,
	// Result stream
	output logic                        res_valid,
	input  wire logic                   res_ready,
	output logic [sat_pkg::RES_W-1:0]   res_data
);
	import sat_pkg::*;
	sat_hst_t          st_r;
	logic [1:0]        eoc_sy_r;
	logic [1:0]        dat_sy_r;
	logic [5:0]        tm_r;
	logic [4:0]        k_r;
	logic [4:0]        len_r;
	logic              ucs_r;
	logic [RES_W-1:0]  rx_r;
	logic [RES_W-1:0]  sh_r;
	logic              push_r;
	logic              fin_rdy;
	logic              take;
	logic              half;
	logic              cs_r;
	logic              ck_r;
	logic              ad_r;
	// ==========================================================
	// Synchronise flag and data line from the converter
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			eoc_sy_r <= 2'h0;
			dat_sy_r <= 2'h0;
		end
		else if (ce)
		begin
			eoc_sy_r <= {eoc_sy_r[0], lnk.eoc};
			dat_sy_r <= {dat_sy_r[0], lnk.dout_w};
		end
	assign take = ce && req_valid && req_ready;
	assign half = (tm_r == 6'(IO_HALF_CYC - 1));
	// ==========================================================
	// Sequencer; clock is divided from clk_sys
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			st_r  <= SAT_IDLE;
			tm_r  <= '0;
			k_r   <= '0;
			len_r <= 5'(FRAME_MIN);
			ucs_r <= 1'b1;
			cs_r  <= 1'b1;
			ck_r  <= 1'b0;
			ad_r  <= 1'b0;
			sh_r  <= '0;
			rx_r  <= '0;
		end
		else if (ce)
		begin
			tm_r <= tm_r + 1'b1;
			case (st_r)
				SAT_IDLE:
					if (take)
					begin
						len_r <= sat_frame_len(req_use_cs, req_len);
						ucs_r <= req_use_cs;
						sh_r  <= {req_chan, 6'h00};
						ad_r  <= req_chan[ADDR_W-1];
						cs_r  <= 1'b0;
						k_r   <= '0;
						tm_r  <= '0;
						st_r  <= SAT_SETUP;
					end
				SAT_SETUP:
					if (tm_r == 6'(GUARD_CYC))
					begin
						tm_r <= '0;
						st_r <= SAT_LO;
					end
				SAT_LO:
					if (half)
					begin
						ck_r <= 1'b1;
						tm_r <= '0;
						st_r <= SAT_HI;
					end
				SAT_HI:
					if (half)
					begin
						ck_r <= 1'b0;
						tm_r <= '0;
						// Sample before the fall: the bit lags each fall by five cycles
						if (k_r < 5'(RES_W))
							rx_r <= {rx_r[RES_W-2:0], dat_sy_r[1]};
						sh_r <= {sh_r[RES_W-2:0], 1'b0};
						ad_r <= sh_r[RES_W-2];
						k_r  <= k_r + 1'b1;
						// Unbroken clocking keeps edge eleven ahead of conversion end
						st_r <= (k_r == len_r - 1'b1) ? SAT_GUARD : SAT_LO;
					end
				SAT_GUARD:
				begin
					cs_r <= !ucs_r;
					if (tm_r == 6'(GUARD_CYC))
						st_r <= SAT_WEOC;
				end
				SAT_WEOC:
					// No new frame or select fall until the flag is high again
					if (eoc_sy_r[1])
						st_r <= SAT_IDLE;
				default:
					st_r <= SAT_IDLE;
			endcase
		end
	// ==========================================================
	// Result push one cycle after the frame ends
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			push_r <= 1'b0;
		else if (ce)
			push_r <= (st_r == SAT_HI) && half && (k_r == len_r - 1'b1);
	// Ready only with room in the queue, so a push is never refused
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			req_ready <= 1'b0;
		else if (ce)
			req_ready <= (st_r == SAT_IDLE) && !take && fin_rdy && !push_r;
	sat_fifo #(
		.W(RES_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.ce       (ce),
		.in_valid (push_r),
		.in_ready (fin_rdy),
		.in_data  (rx_r),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data (res_data)
	);
	// Port drive
	assign lnk.cs_n   = cs_r;
	assign lnk.io_clk = ck_r;
	assign lnk.addr   = ad_r;
endmodule

// File: src/sat_link_if.sv
// Four-wire serial link plus end-of-conversion flag
`timescale 1ns/1ps
interface sat_link_if;
	logic cs_n;
	logic io_clk;
	logic addr;
	logic dout;
	logic dout_oe;
	logic eoc;
	logic dout_w;
	// ==========================================================
	// Released data line floats high
	assign dout_w = dout_oe ? dout : 1'b1;
	modport dev (input cs_n, input io_clk, input addr, output dout, output dout_oe, output eoc);
	modport hst (output cs_n, output io_clk, output addr, input dout_w, input eoc);
endinterface

// File: src/sat_pkg.sv
// Shared constants and types for the serial converter link
package sat_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_NS       = 40;
	localparam int CS_FILT_NS   = 1425;
	localparam int CS_FILT_CYC  = (CS_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_NS      = 21000;
	localparam int CONV_CYC     = CONV_NS / CLK_NS;
	localparam int ABORT_NS     = 9000;
	localparam int ABORT_CYC    = ABORT_NS / CLK_NS;
	localparam int IOCLK_NS     = 320;
	localparam int IO_HALF_CYC  = IOCLK_NS / (2 * CLK_NS);
	localparam int GUARD_CYC    = CS_FILT_CYC + 8;
	// ==========================================================
	// Frame layout
	localparam int RES_W        = 10;
	localparam int ADDR_W       = 4;
	localparam int ACQ_START    = 4;
	localparam int CONV_EDGE    = 10;
	localparam int FRAME_MIN    = 10;
	localparam int FRAME_MAX    = 16;
	localparam int FIFO_DEPTH   = 4;
	// ==========================================================
	// Reset values
	localparam logic [RES_W-1:0] RES_RST = 10'h000;
	localparam logic             EOC_RST = 1'b1;
	// ==========================================================
	// Host sequencer states
	typedef enum logic [2:0] {
		SAT_IDLE  = 3'b000,
		SAT_SETUP = 3'b001,
		SAT_LO    = 3'b010,
		SAT_HI    = 3'b011,
		SAT_GUARD = 3'b100,
		SAT_WEOC  = 3'b101
	} sat_hst_t;
	// Legal frame length for the chosen framing
	function automatic logic [4:0] sat_frame_len(input logic use_cs, input logic [4:0] n);
		if (n <= 5'(FRAME_MIN))
			return 5'(FRAME_MIN);
		else if (!use_cs || n > 5'(FRAME_MAX))
			return 5'(FRAME_MAX);
		else
			return n;
	endfunction
endpackage

// File: tb/sat_bench.sv
// Bench joining host and converter ends through the link
`timescale 1ns/1ps
module sat_bench;
	import sat_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rstn = 1'b0;
	logic              req_valid = 1'b0;
	logic              res_ready = 1'b0;
	logic              req_use_cs = 1'b1;
	logic              io_q = 1'b0;
	logic [4:0]        req_len = 5'h00;
	logic [ADDR_W-1:0] req_chan = 4'h0;
	logic [RES_W-1:0]  ana_data = 10'h000;
	logic [RES_W-1:0]  prev = 10'h000;
	logic              req_ready, res_valid, conv_busy, aborted, sampling;
	logic [ADDR_W-1:0] chan;
	logic [RES_W-1:0]  res_data, result;
	logic [RES_W-1:0]  expq[$];
	int                n_mismatch = 0, n_checks = 0, cyc = 0, nr = 0;
	sat_link_if lnk();
	sat_dev sat_dev_i (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .lnk(lnk), .chan(chan),
		.sampling(sampling), .ana_data(ana_data), .result(result),
		.conv_busy(conv_busy), .aborted(aborted));
	sat_host sat_host_i (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .lnk(lnk),
		.req_valid(req_valid), .req_ready(req_ready), .req_chan(req_chan),
		.req_len(req_len), .req_use_cs(req_use_cs), .res_valid(res_valid),
		.res_ready(res_ready), .res_data(res_data));
	sat_properties sat_properties_i (.clk_sys(clk_sys), .rstn(rstn), .cs_n(lnk.cs_n),
		.io_clk(lnk.io_clk), .dout_oe(lnk.dout_oe), .eoc(lnk.eoc));
	// ====
	// System clock
	always #20 clk_sys = ~clk_sys;
	// Rising serial edges and hang guard
	always @(posedge clk_sys)
	begin
		cyc++;
		if (lnk.io_clk && !io_q)
			nr++;
		io_q = lnk.io_clk;
		if (cyc == 40000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk_word(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input logic [4:0] got, input logic [4:0] exp);
		chk_word(RES_W'(got), RES_W'(exp));
	endtask
	// Clock count that a frame must carry
	function automatic logic [4:0] exp_len(input logic [4:0] n, input logic cs);
		if (n <= 5'h0a)
			return 5'h0a;
		return (!cs || n > 5'h10) ? 5'h10 : n;
	endfunction
	// One frame; input held stable until the next frame starts
	task automatic xfer(input logic [4:0] len, input logic cs, input logic rdy);
		int k;
		req_chan = 4'($urandom);
		ana_data = 10'($urandom);
		req_len = len;
		req_use_cs = cs;
		req_valid = 1'b1;
		expq.push_back(prev);
		prev = ana_data;
		while (!req_ready)
			step();
		step();
		req_valid = 1'b0;
		nr = 0;
		for (k = 0; k < 1200 && !req_ready; k++)
			step();
		chk_cnt(5'(nr), exp_len(len, cs));
		chk_cnt({1'b0, chan}, {1'b0, req_chan});
		chk_cnt({4'h0, req_ready}, {4'h0, rdy});
		chk_word(result, prev);
		chk_cnt({4'h0, conv_busy}, 5'h00);
		chk_cnt({4'h0, sampling}, 5'h00);
		$display("frame done len=%0d cs=%0d", len, cs);
	endtask
	task automatic pop();
		int k;
		res_ready = 1'b1;
		for (k = 0; k < 50 && !res_valid; k++)
			step();
		chk_word(res_data, expq.pop_front());
		step();
		res_ready = 1'b0;
		step();
	endtask
	// ====
	// Corner lengths with and without select, a full buffer, then random frames
	initial
	begin
		static logic [5:0] tbl[7] = '{6'h20, 6'h2a, 6'h2b, 6'h30, 6'h34, 6'h0a, 6'h0d};
		void'($urandom(89));
		repeat (4) @(posedge clk_sys);
		#1 rstn = 1'b1;
		step();
		foreach (tbl[i])
		begin
			xfer(tbl[i][4:0], tbl[i][5], 1'b1);
			pop();
		end
		for (int i = 0; i < 4; i++)
			xfer(5'($urandom_range(16)), 1'b1, 1'(i < 3));
		repeat (4) pop();
		chk_cnt({4'h0, res_valid}, 5'h00);
		repeat (6)
		begin
			xfer(5'($urandom_range(20)), 1'($urandom), 1'b1);
			pop();
		end
		chk_cnt({4'h0, aborted}, 5'h00);
		conclude();
	end
endmodule

// File: tb/sat_properties.sv
// Concurrent checks on the link between converter and host
`timescale 1ns/1ps
module sat_properties (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Link wires
	input wire logic cs_n,
	input wire logic io_clk,
	input wire logic dout_oe,
	input wire logic eoc
);
	import sat_pkg::*;
	localparam int FILT = CS_FILT_CYC;
	localparam int OE_REL = CS_FILT_CYC + 6;
	localparam int CONV_LO = CONV_CYC - 2;
	localparam int CONV_HI = CONV_CYC + 2;
	logic       io_q_r;
	logic [5:0] cslo_r;
	logic [4:0] nr_r;
	logic [4:0] nf_r;
	logic [9:0] lo_r;
	// ====
	// Previous serial clock level
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			io_q_r <= 1'b0;
		else
			io_q_r <= io_clk;
	// Select low time, saturates so long frames never wrap
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			cslo_r <= 6'h00;
		else if (cs_n)
			cslo_r <= 6'h00;
		else if (cslo_r != 6'h3f)
			cslo_r <= cslo_r + 6'h01;
	// Edges of one frame, cleared as conversion ends
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			nr_r <= 5'h00;
			nf_r <= 5'h00;
		end
		else if ($rose(eoc))
		begin
			nr_r <= 5'h00;
			nf_r <= 5'h00;
		end
		else
		begin
			nr_r <= nr_r + 5'(io_clk & !io_q_r);
			nf_r <= nf_r + 5'(!io_clk & io_q_r);
		end
	// Conversion length in system clocks
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			lo_r <= 10'h000;
		else if (eoc)
			lo_r <= 10'h000;
		else
			lo_r <= lo_r + 10'h001;
	// ====
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence s_hi4;
		io_clk[*4];
	endsequence
	sequence s_first_rise;
		$rose(io_clk) && nr_r == 5'h00;
	endsequence
	property p_io_half;
		$rose(io_clk) |-> s_hi4 ##1 !io_clk;
	endproperty
	a_io_half: assert property (p_io_half) else $error("serial clock high time wrong");
	property p_oe_filt;
		$rose(dout_oe) |-> cslo_r >= 6'(FILT);
	endproperty
	a_oe_filt: assert property (p_oe_filt) else $error("data driven before select filter");
	property p_oe_rel;
		$rose(cs_n) |-> ##[1:OE_REL] !dout_oe;
	endproperty
	a_oe_rel: assert property (p_oe_rel) else $error("data not released after select");
	property p_setup;
		$rose(io_clk) |-> cslo_r > 6'(FILT);
	endproperty
	a_setup: assert property (p_setup) else $error("clock before select setup");
	property p_eoc_fall;
		$fell(eoc) |-> nf_r == 5'h0a;
	endproperty
	a_eoc_fall: assert property (p_eoc_fall) else $error("flag fell at wrong edge");
	property p_conv;
		$rose(eoc) |-> lo_r inside {[CONV_LO:CONV_HI]};
	endproperty
	a_conv: assert property (p_conv) else $error("conversion length wrong");
	property p_first;
		s_first_rise |-> eoc;
	endproperty
	a_first: assert property (p_first) else $error("frame began during conversion");
	property p_eleventh;
		$rose(io_clk) && nr_r == 5'h0a |-> !eoc;
	endproperty
	a_eleventh: assert property (p_eleventh) else $error("eleventh edge after conversion");
	property p_len;
		$rose(eoc) |-> nr_r inside {[10:16]};
	endproperty
	a_len: assert property (p_len) else $error("frame length out of range");
endmodule
